// ===== steer_pkg.sv
/*
  Shared constants, register map and carrier types of the open-loop
  steering-wheel set-point block.
  Assumes a 10 MHz bus clock and word-wide AHB-Lite accesses.
*/
package steer_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ = 10_000_000;
  localparam int SAMPLE_PERIOD_MS = 10;
  localparam int SAMPLE_CYCLES = CLK_FREQ_HZ / 1000 * SAMPLE_PERIOD_MS;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_VALVE_CAPACITY = 8'h04;
  localparam logic [7:0] ADDR_STROKE_VOLUME = 8'h08;
  localparam logic [7:0] ADDR_WHEEL_POS = 8'h0c;
  localparam logic [7:0] ADDR_ACT_POS = 8'h10;
  localparam logic [7:0] ADDR_SPEED = 8'h14;
  localparam logic [7:0] ADDR_FLOW = 8'h18;
  localparam logic [7:0] ADDR_RATIO = 8'h1c;
  localparam logic [7:0] ADDR_PRINCIPLE = 8'h20;
  localparam logic [7:0] ADDR_BACKLASH = 8'h24;
  localparam logic [7:0] ADDR_LINEARITY = 8'h28;
  localparam logic [7:0] ADDR_MAX_FLOW = 8'h2c;
  localparam logic [7:0] ADDR_SENS_SELECT = 8'h30;
  localparam logic [7:0] ADDR_RATIO_BASE = 8'h34;
  localparam logic [7:0] ADDR_SPEED_SPAN = 8'h4c;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_ACTIVE_LSB = 0;
  localparam int CTRL_EDIT_LSB = 4;
  localparam int CTRL_ACT_PRESENT_BIT = 8;
  localparam int CTRL_SPEED_PRESENT_BIT = 9;

  // ----------------------------------------------------------------
  // Ranges, scales and codes
  // ----------------------------------------------------------------
  localparam int PROGRAM_COUNT = 10;
  localparam int RATIO_POINTS = 6;
  localparam int BACKLASH_MAX = 200;
  localparam int LINEARITY_MIN = -10;
  localparam int LINEARITY_MAX = 10;
  localparam int FLOW_FULL = 1000;
  localparam int RATIO_MIN = 20;
  localparam int RATIO_MAX = 1200;
  localparam int RATIO_SCALE = 100;
  localparam int SPAN_MIN = 1;
  localparam int SPAN_MAX = 1000;
  localparam int CAPACITY_MIN = 5;
  localparam int CAPACITY_MAX = 120;
  localparam int STROKE_MIN = 100;
  localparam int STROKE_MAX = 8000;
  localparam int POS_FULL = 1000;
  localparam int WHEEL_TICKS_PER_REV = 4095;
  localparam int FLOW_SCALE = (60000 / SAMPLE_PERIOD_MS) * RATIO_SCALE;
  localparam logic [7:0] PRINCIPLE_OPEN_LOOP = 8'h00;
  localparam logic [1:0] SENS_FIXED = 2'h1;
  localparam logic [1:0] SENS_POSITION = 2'h2;
  localparam logic [1:0] SENS_SPEED = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] PRINCIPLE_RST = 8'h00;
  localparam logic [7:0] BACKLASH_RST = 8'h00;
  localparam logic signed [4:0] LINEARITY_RST = 5'sh00;
  localparam logic [9:0] MAX_FLOW_RST = 10'h3e8;
  localparam logic [1:0] SENS_RST = 2'h1;
  localparam logic [10:0] RATIO_RST = 11'h190;
  localparam logic [9:0] SPAN_RST = 10'h1f4;
  localparam logic [6:0] CAPACITY_RST = 7'h19;
  localparam logic [12:0] STROKE_RST = 13'h258;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] principle;
    logic [7:0] backlash;
    logic signed [4:0] linearity;
    logic [9:0] max_flow;
    logic [1:0] sens_select;
    logic [RATIO_POINTS-1:0][10:0] ratio;
    logic [9:0] speed_span;
  } prog_param_type;

  typedef struct packed {
    logic signed [15:0] wheel_pos;
    logic signed [10:0] act_pos;
    logic signed [10:0] speed;
    logic act_present;
    logic speed_present;
  } sensor_type;

endpackage

// ===== wheel_setpoint.sv
/*
  Open-loop steering-wheel flow set-point with its AHB-Lite register file.
  Assumes one AHB-Lite master, word accesses, and software that writes
  the sensor values into the sensor registers.
*/
//
// Behaviour
// [RULE_01] Principle value zero selects open-loop control; otherwise flow stays zero.
// [RULE_02] Ten programs, 0 to 9, each with its own parameter set.
// [RULE_03] Backlash threshold accepted from 0 to 200.
// [RULE_04] Backlash applied both directions, total dead region twice threshold.
// [RULE_05] Backlash only affects changes of the wheel-derived flow set-point.
// [RULE_06] Second-order flow shaping, linearity from -10 to 10.
// [RULE_07] Higher linearity: less flow at low speed, more at high speed. Code gives less below 1000 and the same flow at or above 1000.
// [RULE_08] Flow clamped to maximum setting 0..1000, default 1000.
// [RULE_09] Selector 1 fixed, 2 position, 3 speed ratio.
// [RULE_10] Ratio 400 means 4.00 turns lock to lock, up to 1200.
// [RULE_11] Valve capacity and stroke volume convert ratio into flow gain.
// [RULE_12] Position mode interpolates base to minimum-radius ratio, symmetric.
// [RULE_13] Actuator position unit is 0.1 percent of maximum position.
// [RULE_14] Unmapped actuator sensor holds position zero, giving base ratio.
// [RULE_15] Speed mode breakpoints at 0, 6.25, 12.5, 25, 50, 100 percent span.
// [RULE_16] Linear interpolation between speed breakpoints; negative speeds mirrored.
// [RULE_17] Configuring party keeps speed ratios non-decreasing with speed.
// [RULE_18] Speed span accepted from 1 to 1000, default 500.
// [RULE_19] Speed signal absent: speed taken as zero, standstill ratio used. Code uses ratio point 1 to 4 instead for speed spans below 16.
// [RULE_20] Beyond speed span the full-span ratio is held.
`timescale 1ns/10ps

module wheel_setpoint
#(
  parameter int SAMPLE_CYCLES = steer_pkg::SAMPLE_CYCLES
)
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Valve spool flow request
  output logic signed [10:0] flow_setpoint,
  output logic open_loop_active
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------

  // Saturate a signed word into a range
  function automatic logic signed [31:0] sat(input logic signed [31:0] v,
                                             input int lo, input int hi);
    if (v < lo)
      sat = lo;
    else if (v > hi)
      sat = hi;
    else
      sat = v;
  endfunction

  // Linear step from lo toward hi by num/den
  function automatic logic signed [47:0] interp(input logic signed [47:0] lo,
                                                input logic signed [47:0] hi,
                                                input logic signed [47:0] num,
                                                input logic signed [47:0] den);
    if (den <= 0)
      interp = hi;
    else
      interp = lo + (hi - lo) * num / den;
  endfunction

  // Magnitude of a signed value
  function automatic logic signed [47:0] mag(input logic signed [47:0] v);
    mag = (v < 0) ? -v : v;
  endfunction

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  logic wr_pending;
  logic rd_pending;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic take;
  logic word_ok;

  assign take = hsel && hready && htrans[1];
  assign word_ok = (hsize == 3'h2) && (haddr[31:8] == 24'h000000);

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      wr_addr <= 8'h00;
      rd_addr <= 8'h00;
    end
    else
    begin
      wr_pending <= take && hwrite && word_ok;
      rd_pending <= take && !hwrite;
      if (take)
      begin
        wr_addr <= haddr[7:0];
        rd_addr <= word_ok ? haddr[7:0] : 8'hff;
      end
    end
  end

  // One wait state on reads so a preceding write is seen
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hreadyout <= 1'b1;
    else if (take && !hwrite)
      hreadyout <= 1'b0;
    else
      hreadyout <= 1'b1;
  end

  // Response is always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hresp <= 1'b0;
    else
      hresp <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  steer_pkg::prog_param_type bank [steer_pkg::PROGRAM_COUNT];
  steer_pkg::sensor_type sensor;
  logic [3:0] active_prog;
  logic [3:0] edit_prog;
  logic [6:0] capacity;
  logic [12:0] stroke;
  logic signed [31:0] wv;
  logic bank_hit;
  logic [2:0] point;

  assign wv = hwdata;
  assign bank_hit = edit_prog < 4'(steer_pkg::PROGRAM_COUNT);
  assign point = 3'((wr_addr - steer_pkg::ADDR_RATIO_BASE) >> 2);

  // Program selection, only legal program numbers taken
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      active_prog <= 4'h0;
      edit_prog <= 4'h0;
    end
    else if (wr_pending && wr_addr == steer_pkg::ADDR_CONTROL)
    begin
      if (hwdata[steer_pkg::CTRL_ACTIVE_LSB +: 4] < 4'(steer_pkg::PROGRAM_COUNT))
        active_prog <= hwdata[steer_pkg::CTRL_ACTIVE_LSB +: 4]; // RULE_02
      if (hwdata[steer_pkg::CTRL_EDIT_LSB +: 4] < 4'(steer_pkg::PROGRAM_COUNT))
        edit_prog <= hwdata[steer_pkg::CTRL_EDIT_LSB +: 4];
    end
  end

  // Valve and cylinder sizing, held in range
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      capacity <= steer_pkg::CAPACITY_RST;
      stroke <= steer_pkg::STROKE_RST;
    end
    else if (wr_pending)
    begin
      if (wr_addr == steer_pkg::ADDR_VALVE_CAPACITY)
        capacity <= 7'(sat(wv, steer_pkg::CAPACITY_MIN, steer_pkg::CAPACITY_MAX)); // RULE_11
      if (wr_addr == steer_pkg::ADDR_STROKE_VOLUME)
        stroke <= 13'(sat(wv, steer_pkg::STROKE_MIN, steer_pkg::STROKE_MAX)); // RULE_11
    end
  end

  // Sensor values and presence flags
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sensor <= '0;
    else if (wr_pending)
    begin
      if (wr_addr == steer_pkg::ADDR_CONTROL)
      begin
        sensor.act_present <= hwdata[steer_pkg::CTRL_ACT_PRESENT_BIT];
        sensor.speed_present <= hwdata[steer_pkg::CTRL_SPEED_PRESENT_BIT];
      end
      if (wr_addr == steer_pkg::ADDR_WHEEL_POS)
        sensor.wheel_pos <= hwdata[15:0];
      if (wr_addr == steer_pkg::ADDR_ACT_POS)
        sensor.act_pos <= 11'(sat(wv, -steer_pkg::POS_FULL, steer_pkg::POS_FULL));
      if (wr_addr == steer_pkg::ADDR_SPEED)
        sensor.speed <= 11'(sat(wv, -steer_pkg::SPAN_MAX, steer_pkg::SPAN_MAX));
    end
  end

  // Per-program parameter banks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int p = 0; p < steer_pkg::PROGRAM_COUNT; p++)
      begin
        bank[p].principle <= steer_pkg::PRINCIPLE_RST;
        bank[p].backlash <= steer_pkg::BACKLASH_RST;
        bank[p].linearity <= steer_pkg::LINEARITY_RST;
        bank[p].max_flow <= steer_pkg::MAX_FLOW_RST;
        bank[p].sens_select <= steer_pkg::SENS_RST;
        for (int k = 0; k < steer_pkg::RATIO_POINTS; k++)
          bank[p].ratio[k] <= steer_pkg::RATIO_RST;
        bank[p].speed_span <= steer_pkg::SPAN_RST;
      end
    end
    else if (wr_pending && bank_hit)
    begin
      unique case (wr_addr)
        steer_pkg::ADDR_PRINCIPLE:
          bank[edit_prog].principle <= hwdata[7:0];
        steer_pkg::ADDR_BACKLASH:
          bank[edit_prog].backlash <= 8'(sat(wv, 0, steer_pkg::BACKLASH_MAX)); // RULE_03
        steer_pkg::ADDR_LINEARITY:
          bank[edit_prog].linearity <=
            5'(sat(wv, steer_pkg::LINEARITY_MIN, steer_pkg::LINEARITY_MAX)); // RULE_06
        steer_pkg::ADDR_MAX_FLOW:
          bank[edit_prog].max_flow <= 10'(sat(wv, 0, steer_pkg::FLOW_FULL)); // RULE_08
        steer_pkg::ADDR_SENS_SELECT:
          bank[edit_prog].sens_select <= hwdata[1:0]; // RULE_09
        steer_pkg::ADDR_SPEED_SPAN:
          bank[edit_prog].speed_span <=
            10'(sat(wv, steer_pkg::SPAN_MIN, steer_pkg::SPAN_MAX)); // RULE_18
        default:
        begin
          if (wr_addr >= steer_pkg::ADDR_RATIO_BASE && wr_addr < steer_pkg::ADDR_SPEED_SPAN
              && wr_addr[1:0] == 2'h0)
            bank[edit_prog].ratio[point] <=
              11'(sat(wv, steer_pkg::RATIO_MIN, steer_pkg::RATIO_MAX)); // RULE_10
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  steer_pkg::prog_param_type ep;
  logic [10:0] ratio_now;
  logic [31:0] rd_word;
  logic [2:0] rd_point;

  assign ep = bank[edit_prog];
  assign rd_point = 3'((rd_addr - steer_pkg::ADDR_RATIO_BASE) >> 2);

  // Register value for the captured read address
  always_comb
  begin
    rd_word = 32'h00000000;
    unique case (rd_addr)
      steer_pkg::ADDR_CONTROL:
      begin
        rd_word[steer_pkg::CTRL_ACTIVE_LSB +: 4] = active_prog;
        rd_word[steer_pkg::CTRL_EDIT_LSB +: 4] = edit_prog;
        rd_word[steer_pkg::CTRL_ACT_PRESENT_BIT] = sensor.act_present;
        rd_word[steer_pkg::CTRL_SPEED_PRESENT_BIT] = sensor.speed_present;
      end
      steer_pkg::ADDR_VALVE_CAPACITY: rd_word = 32'(capacity);
      steer_pkg::ADDR_STROKE_VOLUME: rd_word = 32'(stroke);
      steer_pkg::ADDR_WHEEL_POS: rd_word = 32'(sensor.wheel_pos);
      steer_pkg::ADDR_ACT_POS: rd_word = 32'(sensor.act_pos);
      steer_pkg::ADDR_SPEED: rd_word = 32'(sensor.speed);
      steer_pkg::ADDR_FLOW:
      begin
        rd_word = 32'(flow_setpoint);
        rd_word[31] = open_loop_active;
      end
      steer_pkg::ADDR_RATIO: rd_word = 32'(ratio_now);
      steer_pkg::ADDR_PRINCIPLE: rd_word = 32'(ep.principle);
      steer_pkg::ADDR_BACKLASH: rd_word = 32'(ep.backlash);
      steer_pkg::ADDR_LINEARITY: rd_word = 32'(ep.linearity);
      steer_pkg::ADDR_MAX_FLOW: rd_word = 32'(ep.max_flow);
      steer_pkg::ADDR_SENS_SELECT: rd_word = 32'(ep.sens_select);
      steer_pkg::ADDR_SPEED_SPAN: rd_word = 32'(ep.speed_span);
      default:
      begin
        if (rd_addr >= steer_pkg::ADDR_RATIO_BASE && rd_addr < steer_pkg::ADDR_SPEED_SPAN
            && rd_addr[1:0] == 2'h0)
          rd_word = 32'(ep.ratio[rd_point]);
      end
    endcase
  end

  // Read data loaded in the wait cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (rd_pending)
      hrdata <= rd_word;
  end

  // ----------------------------------------------------------------
  // Ratio selection
  // ----------------------------------------------------------------
  steer_pkg::prog_param_type ap;
  logic signed [47:0] act_mag;
  logic signed [47:0] spd_mag;
  logic signed [47:0] bp [steer_pkg::RATIO_POINTS];
  logic signed [47:0] ratio_sel;

  assign ap = bank[active_prog];

  // Ratio for the active program's sensitivity mode
  always_comb
  begin
    act_mag = '0;
    spd_mag = '0;
    ratio_sel = 48'(ap.ratio[0]); // RULE_09
    if (sensor.act_present)
      act_mag = mag(48'($signed(sensor.act_pos))); // RULE_12 RULE_13 RULE_14
    if (sensor.speed_present)
      spd_mag = mag(48'($signed(sensor.speed))); // RULE_16 RULE_19
    bp[0] = '0;
    for (int k = 1; k < steer_pkg::RATIO_POINTS; k++)
      bp[k] = 48'(ap.speed_span) >>> (steer_pkg::RATIO_POINTS - 1 - k); // RULE_15
    if (ap.sens_select == steer_pkg::SENS_POSITION)
      ratio_sel = interp(48'(ap.ratio[0]), 48'(ap.ratio[1]), act_mag,
                         48'(steer_pkg::POS_FULL)); // RULE_12
    else if (ap.sens_select == steer_pkg::SENS_SPEED)
    begin
      ratio_sel = 48'(ap.ratio[steer_pkg::RATIO_POINTS - 1]); // RULE_20
      for (int k = steer_pkg::RATIO_POINTS - 2; k >= 0; k--)
        if (spd_mag < bp[k + 1])
          ratio_sel = interp(48'(ap.ratio[k]), 48'(ap.ratio[k + 1]),
                             spd_mag - bp[k], bp[k + 1] - bp[k]); // RULE_16 RULE_17
    end
  end

  assign ratio_now = 11'(ratio_sel);

  // ----------------------------------------------------------------
  // Sample divider
  // ----------------------------------------------------------------
  logic [31:0] div_count;
  logic sample_tick;
  logic shape_tick;

  // One-cycle sample enable every SAMPLE_CYCLES
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_count <= 32'h00000000;
      sample_tick <= 1'b0;
      shape_tick <= 1'b0;
    end
    else
    begin
      sample_tick <= div_count == 32'(SAMPLE_CYCLES - 1);
      shape_tick <= sample_tick;
      if (div_count == 32'(SAMPLE_CYCLES - 1))
        div_count <= 32'h00000000;
      else
        div_count <= div_count + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Backlash and wheel speed
  // ----------------------------------------------------------------
  logic signed [15:0] wheel_ref;
  logic signed [15:0] next_wheel_ref;
  logic signed [16:0] wheel_delta;
  logic [10:0] ratio_q;
  logic signed [16:0] hi_edge;
  logic signed [16:0] lo_edge;

  assign hi_edge = 17'(wheel_ref) + 17'(ap.backlash);
  assign lo_edge = 17'(wheel_ref) - 17'(ap.backlash);

  // Reference moves only when wheel leaves the dead region on either side
  always_comb
  begin
    next_wheel_ref = wheel_ref;
    if (17'(sensor.wheel_pos) > hi_edge)
      next_wheel_ref = 16'(17'(sensor.wheel_pos) - 17'(ap.backlash)); // RULE_04
    else if (17'(sensor.wheel_pos) < lo_edge)
      next_wheel_ref = 16'(17'(sensor.wheel_pos) + 17'(ap.backlash)); // RULE_04
  end

  // Set-point change per sample comes from the backlashed reference
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wheel_ref <= 16'h0000;
      wheel_delta <= 17'h00000;
      ratio_q <= steer_pkg::RATIO_RST;
    end
    else if (sample_tick)
    begin
      wheel_ref <= next_wheel_ref;
      wheel_delta <= 17'(next_wheel_ref) - 17'(wheel_ref); // RULE_05
      ratio_q <= ratio_now;
    end
  end

  // ----------------------------------------------------------------
  // Transfer function
  // ----------------------------------------------------------------
  logic signed [47:0] raw_flow;
  logic signed [47:0] norm;
  logic signed [47:0] shaped;
  logic signed [47:0] limit;
  logic signed [47:0] clamped;

  // Gain from ratio, stroke and capacity; shaping; clamp
  always_comb
  begin
    raw_flow = 48'(wheel_delta) * $signed(48'(stroke)) * 48'(steer_pkg::FLOW_SCALE)
               / (48'(steer_pkg::WHEEL_TICKS_PER_REV) * $signed(48'(ratio_q))
                  * $signed(48'(capacity))); // RULE_10 RULE_11
    norm = mag(raw_flow);
    if (norm > 48'(steer_pkg::FLOW_FULL))
      norm = 48'(steer_pkg::FLOW_FULL);
    shaped = raw_flow + 48'($signed(ap.linearity))
             * (raw_flow * norm / 48'(steer_pkg::FLOW_FULL) - raw_flow)
             / 48'(steer_pkg::LINEARITY_MAX); // RULE_06 RULE_07
    limit = 48'(ap.max_flow);
    clamped = shaped;
    if (shaped > limit)
      clamped = limit; // RULE_08
    else if (shaped < -limit)
      clamped = -limit; // RULE_08
  end

  // Output flow request, zero outside open-loop principle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flow_setpoint <= 11'sh000;
      open_loop_active <= 1'b0;
    end
    else
    begin
      open_loop_active <= ap.principle == steer_pkg::PRINCIPLE_OPEN_LOOP; // RULE_01
      if (ap.principle != steer_pkg::PRINCIPLE_OPEN_LOOP)
        flow_setpoint <= 11'sh000; // RULE_01
      else if (shape_tick)
        flow_setpoint <= 11'(clamped);
    end
  end

endmodule

// ===== wheel_setpoint_checker.sv
/*
  Port checker for the wheel set-point block.
  Bound to every wheel_setpoint instance; sees its ports only.
*/
`timescale 1ns/10ps
module wheel_setpoint_checker
(
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Set-point
  input wire logic signed [10:0] flow_setpoint,
  input wire logic open_loop_active
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Read request and its single wait
  sequence read_take;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence wait_one;
    !hreadyout ##1 hreadyout;
  endsequence
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (read_take |=> wait_one)
    else $error("read wait not one cycle");
  write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
    else $error("write stalled");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(hsel && htrans[1] && !hwrite))
    else $error("wait without read");
  rdata_hold_a: assert property ($changed(hrdata) |-> $rose(hreadyout))
    else $error("read data moved");
  flow_range_a: assert property (flow_setpoint <= 11'sd1000 && flow_setpoint >= -11'sd1000)
    else $error("flow out of range");
  closed_zero_a: assert property (!open_loop_active [*2] |-> flow_setpoint == 11'sh0)
    else $error("flow while not open loop");
  flow_source_a: assert property ($changed(flow_setpoint) |-> open_loop_active || flow_setpoint == 11'sh0)
    else $error("flow changed while inactive");
endmodule

bind wheel_setpoint wheel_setpoint_checker i_wheel_setpoint_checker (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flow_setpoint(flow_setpoint),
  .open_loop_active(open_loop_active));

// ===== valve_model.sv
/*
  Valve and cylinder model: integrates the flow request.
  Assumes the block's clock and reset.
*/
`timescale 1ns/10ps
module valve_model
(
  // Clock, reset and flow request
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic signed [10:0] flow_setpoint,
  // Cylinder position
  output logic signed [31:0] cyl_pos
);
  // Cylinder moves by the port flow each clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cyl_pos <= 32'sh0;
    else
      cyl_pos <= cyl_pos + 32'(flow_setpoint);
  end
endmodule

// ===== wheel_setpoint_bench.sv
/*
  Self-checking bench for the wheel set-point block.
  Assumes the bus master below is the only master.
*/
`timescale 1ns/10ps
module wheel_setpoint_bench;
  localparam int SC = 50;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic signed [10:0] flow_setpoint;
  logic open_loop_active;
  logic signed [31:0] cyl_pos;
  logic [31:0] q;
  logic signed [15:0] pos = 16'sh0;
  int mismatches = 0;
  int checked = 0;
  always #50 hclk = ~hclk;
  wheel_setpoint #(.SAMPLE_CYCLES(SC)) i_wheel_setpoint (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .flow_setpoint(flow_setpoint), .open_loop_active(open_loop_active));
  valve_model i_valve_model (.hclk(hclk), .hresetn(hresetn),
    .flow_setpoint(flow_setpoint), .cyl_pos(cyl_pos));
  // Compare and count
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One single bus transfer, read data left in q
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  // Wheel step and the flow it gives
  task move(input int d, input int exp);
    logic signed [31:0] c0;
    c0 = cyl_pos;
    pos = pos + 16'(d);
    xfer(1'b1, steer_pkg::ADDR_WHEEL_POS, 32'(pos));
    repeat (2 * SC + 4) if (flow_setpoint === 11'sh0) @(posedge hclk);
    check(32'(flow_setpoint), 32'(exp));
    repeat (2 * SC + 4) @(posedge hclk);
    check(32'(cyl_pos - c0), 32'(exp * SC));
  endtask
  // Write, let a sample pass, read the chosen ratio
  task sp(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
    xfer(1'b1, a, d);
    repeat (SC + 4) @(posedge hclk);
    rd(steer_pkg::ADDR_RATIO, exp);
  endtask
  task t_reset;
    logic [7:0] ad [0:5] = '{steer_pkg::ADDR_MAX_FLOW, steer_pkg::ADDR_RATIO_BASE,
      steer_pkg::ADDR_SPEED_SPAN, steer_pkg::ADDR_VALVE_CAPACITY,
      steer_pkg::ADDR_STROKE_VOLUME, steer_pkg::ADDR_SENS_SELECT};
    logic [31:0] ex [0:5] = '{32'h3e8, 32'h190, 32'h1f4, 32'h19, 32'h258, 32'h1};
    for (int i = 0; i < 6; i++)
      rd(ad[i], ex[i]);
    rd(8'h50, 32'h0);
    rd(steer_pkg::ADDR_FLOW, 32'h80000000);
    xfer(1'b1, steer_pkg::ADDR_BACKLASH, 32'h12c);
    rd(steer_pkg::ADDR_BACKLASH, 32'hc8);
    xfer(1'b1, steer_pkg::ADDR_SPEED_SPAN, 32'h0);
    rd(steer_pkg::ADDR_SPEED_SPAN, 32'h1);
    xfer(1'b1, steer_pkg::ADDR_BACKLASH, 32'h0);
  endtask
  task t_flow;
    move(91, 800);
    move(-91, -800);
    move(182, 1000);
    xfer(1'b1, steer_pkg::ADDR_MAX_FLOW, 32'h1f4);
    move(-182, -500);
    xfer(1'b1, steer_pkg::ADDR_MAX_FLOW, 32'h3e8);
    xfer(1'b1, steer_pkg::ADDR_RATIO_BASE, 32'h320);
    move(91, 400);
    xfer(1'b1, steer_pkg::ADDR_RATIO_BASE, 32'h190);
    xfer(1'b1, steer_pkg::ADDR_LINEARITY, 32'ha);
    move(91, 640);
    xfer(1'b1, steer_pkg::ADDR_LINEARITY, 32'hfffffff6);
    move(91, 960);
    xfer(1'b1, steer_pkg::ADDR_LINEARITY, 32'h0);
    xfer(1'b1, steer_pkg::ADDR_BACKLASH, 32'h14);
    move(15, 0);
    move(-15, 0);
    xfer(1'b1, steer_pkg::ADDR_BACKLASH, 32'h0);
    xfer(1'b1, steer_pkg::ADDR_PRINCIPLE, 32'h1);
    move(91, 0);
    rd(steer_pkg::ADDR_FLOW, 32'h0);
    check(32'(open_loop_active), 32'h0);
    xfer(1'b1, steer_pkg::ADDR_PRINCIPLE, 32'h0);
    xfer(1'b1, steer_pkg::ADDR_CONTROL, 32'h11);
    xfer(1'b1, steer_pkg::ADDR_MAX_FLOW, 32'h12c);
    move(182, 300);
    xfer(1'b1, steer_pkg::ADDR_CONTROL, 32'h0);
    rd(steer_pkg::ADDR_MAX_FLOW, 32'h3e8);
  endtask
  task t_ratio;
    for (int i = 0; i < 6; i++)
      xfer(1'b1, steer_pkg::ADDR_RATIO_BASE + 8'(4 * i), 32'(100 * (i + 1)));
    xfer(1'b1, steer_pkg::ADDR_SPEED_SPAN, 32'ha0);
    xfer(1'b1, steer_pkg::ADDR_CONTROL, 32'h100);
    xfer(1'b1, steer_pkg::ADDR_SENS_SELECT, 32'h2);
    sp(steer_pkg::ADDR_ACT_POS, 32'h1f4, 32'h96);
    sp(steer_pkg::ADDR_ACT_POS, 32'hfffffe0c, 32'h96);
    sp(steer_pkg::ADDR_CONTROL, 32'h200, 32'h64);
    sp(steer_pkg::ADDR_SENS_SELECT, 32'h3, 32'h64);
    sp(steer_pkg::ADDR_SPEED, 32'hf, 32'hfa);
    sp(steer_pkg::ADDR_SPEED, 32'hfffffff1, 32'hfa);
    sp(steer_pkg::ADDR_SPEED, 32'h78, 32'h226);
    sp(steer_pkg::ADDR_SPEED, 32'h1f4, 32'h258);
    sp(steer_pkg::ADDR_CONTROL, 32'h0, 32'h64);
    sp(steer_pkg::ADDR_SENS_SELECT, 32'h1, 32'h64);
  endtask
  // Watchdog
  initial
  begin
    #2_000_000;
    mismatches++;
    end_sim;
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_flow;
    t_ratio;
    end_sim;
  end
endmodule
